// file: common/bp_defs.svh
`ifndef BP_DEFS_SVH
`define BP_DEFS_SVH
`define ADDR_W        32
`define HIST_ENTRIES  16
`define HIST_IDX_W    4
`define CTR_W         2
`define CTR_INIT      2'h2
`define CTR_TAKEN_MIN 2'h2
`define SPIN_GUARD_CYC 4
`endif

// file: common/bp_pkg.sv
package bp_pkg;
  typedef enum logic [2:0] {
    BR_NONE, BR_UNCOND, BR_COND, BR_INDIRECT, BR_IND_CALL, BR_SPIN_HINT
  } br_kind_t;
  typedef enum logic [1:0] {
    VAR_DIRECTION, VAR_DYN_COND, VAR_NO_STATIC
  } variant_t;
  typedef struct packed {
    logic        valid;
    br_kind_t    kind;
    logic [31:0] pc;
    logic [31:0] target;
  } fetch_br_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] target;
    logic        taken;
  } resolve_t;
  typedef struct packed {
    logic        valid;
    logic        taken;
    logic        from_static;
    logic        from_history;
    logic [31:0] next_pc;
  } predict_t;
endpackage

// file: core/static_dir.sv
`timescale 1ns/100ps
`include "bp_defs.svh"
module static_dir
  import bp_pkg::*;
#(
  parameter variant_t VARIANT = VAR_DIRECTION
) (
  input  wire br_kind_t    kind,
  input  wire logic [31:0] pc,
  input  wire logic [31:0] target,
  output logic             use_static,
  output logic             taken
);
  function automatic logic is_backward(input logic [31:0] p, input logic [31:0] t);
    return t <= p;
  endfunction

  always_comb begin
    use_static = 1'b0;
    taken      = 1'b0;
    if (VARIANT != VAR_NO_STATIC) begin
      unique case (kind)
        BR_UNCOND: begin
          use_static = 1'b1;
          taken      = 1'b1;
        end
        BR_INDIRECT, BR_IND_CALL: begin
          use_static = 1'b1;
          taken      = 1'b0;
        end
        BR_COND: begin
          if (VARIANT == VAR_DIRECTION) begin
            use_static = 1'b1;
            taken      = is_backward(pc, target);
          end
        end
        BR_NONE, BR_SPIN_HINT: begin
          use_static = 1'b0;
        end
        default: begin
          use_static = 1'b0;
        end
      endcase
    end
  end
endmodule // static_dir

// file: core/target_history_buffer.sv
`timescale 1ns/100ps
`include "bp_defs.svh"
module target_history_buffer
  import bp_pkg::*;
#(
  parameter int ENTRIES = `HIST_ENTRIES,
  parameter int IDX_W   = `HIST_IDX_W
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] look_pc,
  output logic             hit,
  output logic             hit_taken,
  output logic [31:0]      hit_target,
  input  wire resolve_t    upd,
  input  wire logic        upd_cond
);
  logic                        vld_reg  [ENTRIES];
  logic [31:0]                 tag_reg  [ENTRIES];
  logic [31:0]                 tgt_reg  [ENTRIES];
  logic [`CTR_W-1:0]           ctr_reg  [ENTRIES];
  logic                        vld_next [ENTRIES];
  logic [31:0]                 tag_next [ENTRIES];
  logic [31:0]                 tgt_next [ENTRIES];
  logic [`CTR_W-1:0]           ctr_next [ENTRIES];

  function automatic logic [IDX_W-1:0] idx_of(input logic [31:0] a);
    return a[IDX_W+1:2];
  endfunction

  logic [IDX_W-1:0] li;
  logic [IDX_W-1:0] ui;
  logic             upd_hit;

  assign li         = idx_of(look_pc);
  assign ui         = idx_of(upd.pc);
  assign hit        = vld_reg[li] && (tag_reg[li] == look_pc);
  assign hit_taken  = ctr_reg[li] >= `CTR_TAKEN_MIN;
  assign hit_target = tgt_reg[li];
  assign upd_hit    = vld_reg[ui] && (tag_reg[ui] == upd.pc);

  always_comb begin
    vld_next = vld_reg;
    tag_next = tag_reg;
    tgt_next = tgt_reg;
    ctr_next = ctr_reg;
    if (upd.valid) begin
      if (upd_hit) begin
        tgt_next[ui] = upd.taken ? upd.target : tgt_reg[ui];
        if (!upd_cond) begin
          ctr_next[ui] = 2'h3;
        end else if (upd.taken && ctr_reg[ui] != 2'h3) begin
          ctr_next[ui] = ctr_reg[ui] + 2'h1;
        end else if (!upd.taken && ctr_reg[ui] != 2'h0) begin
          ctr_next[ui] = ctr_reg[ui] - 2'h1;
        end
      end else if (upd.taken) begin
        // Only taken branches claim an entry; evicting the old one is the cost
        vld_next[ui] = 1'b1;
        tag_next[ui] = upd.pc;
        tgt_next[ui] = upd.target;
        ctr_next[ui] = `CTR_INIT;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        vld_reg[i] <= 1'b0;
        tag_reg[i] <= 32'h0;
        tgt_reg[i] <= 32'h0;
        ctr_reg[i] <= 2'h0;
      end
    end else begin
      vld_reg <= vld_next;
      tag_reg <= tag_next;
      tgt_reg <= tgt_next;
      ctr_reg <= ctr_next;
    end
  end
endmodule // target_history_buffer

// file: core/static_branch_predictor.sv
`timescale 1ns/100ps
`include "bp_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Branches missing in the history buffer use the static heuristic unless the variant predicts them dynamically.
// - Static: unconditional branches predicted taken.
// - Static: indirect branches and calls predicted not taken, fall-through.
// - Direction variant: backward conditional branches predicted taken.
// - Direction variant: forward conditional branches predicted not taken.
// - Dynamic variant: every conditional branch predicted dynamically, even first time.
// - Newest variant: no static heuristic at all.
// - Never-taken conditional branches get no history entry.
// - Taken branches allocate entries, consuming capacity.
// - Backward branch missing first pass: no buffer prediction, static taken.
// - Spin-wait hint is predicted exactly as a no-operation.
// - Spin-wait hint marks a polling loop, lowering order-violation detection.
// - Without the hint a loop exit may flag an order violation.
////////////////////////////////////////////////////////////////////////////////
module static_branch_predictor
  import bp_pkg::*;
#(
  parameter variant_t VARIANT = VAR_DIRECTION,
  parameter int       ENTRIES = `HIST_ENTRIES,
  parameter int       IDX_W   = `HIST_IDX_W
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire fetch_br_t fetch,
  input  wire logic      dyn_taken,
  input  wire resolve_t  resolve,
  input  wire logic      resolve_cond,
  input  wire logic      loop_exit,
  input  wire logic      order_hazard,
  output predict_t       pred,
  output logic           order_flush
);
  ////////////////////////////////////////////////////////////////////////////
  logic        hit;
  logic        hit_taken;
  logic [31:0] hit_target;
  logic        use_static;
  logic        st_taken;

  target_history_buffer #(
    .ENTRIES (ENTRIES),
    .IDX_W   (IDX_W)
  ) u_hist (
    .clk        (clk),
    .rst_n      (rst_n),
    .look_pc    (fetch.pc),
    .hit        (hit),
    .hit_taken  (hit_taken),
    .hit_target (hit_target),
    .upd        (resolve),
    .upd_cond   (resolve_cond)
  );

  static_dir #(
    .VARIANT (VARIANT)
  ) u_static (
    .kind       (fetch.kind),
    .pc         (fetch.pc),
    .target     (fetch.target),
    .use_static (use_static),
    .taken      (st_taken)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Prediction stage
  predict_t pred_reg;
  predict_t pred_next;
  logic     taken_c;
  logic     stat_c;
  logic     hist_c;

  always_comb begin
    taken_c = 1'b0;
    stat_c  = 1'b0;
    hist_c  = 1'b0;
    if (fetch.kind == BR_SPIN_HINT || fetch.kind == BR_NONE) begin
      // A hint sharing a slot with a stored branch must not claim its history
      taken_c = 1'b0;
    end else if (hit) begin
      taken_c = hit_taken;
      hist_c  = 1'b1;
    end else if (use_static) begin
      taken_c = st_taken;
      stat_c  = 1'b1;
    end else begin
      // Conditional under dynamic variants, or everything with no heuristic
      taken_c = dyn_taken;
    end
    pred_next.valid        = fetch.valid;
    pred_next.taken        = fetch.valid && taken_c;
    pred_next.from_static  = fetch.valid && stat_c;
    pred_next.from_history = fetch.valid && hist_c;
    if (fetch.valid && taken_c) begin
      pred_next.next_pc = hist_c ? hit_target : fetch.target;
    end else begin
      pred_next.next_pc = fetch.pc + 32'h4;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pred_reg <= '0;
    end else begin
      pred_reg <= pred_next;
    end
  end

  assign pred = pred_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Spin-wait guard: a recent hint suppresses order-violation flush on exit
  logic [2:0] guard_reg;
  logic [2:0] guard_next;
  logic       flush_reg;
  logic       flush_next;

  always_comb begin
    guard_next = (guard_reg != 3'h0) ? guard_reg - 3'h1 : 3'h0;
    if (fetch.valid && fetch.kind == BR_SPIN_HINT) begin
      guard_next = 3'(`SPIN_GUARD_CYC);
    end
    // Exit with no hint in the last SPIN_GUARD_CYC cycles pays the full recovery flush
    flush_next = loop_exit && order_hazard && (guard_reg == 3'h0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_reg <= 3'h0;
      flush_reg <= 1'b0;
    end else begin
      guard_reg <= guard_next;
      flush_reg <= flush_next;
    end
  end

  assign order_flush = flush_reg;
endmodule // static_branch_predictor

// file: sim/sbp_asserts.sv
`timescale 1ns/100ps
module sbp_asserts
  import bp_pkg::*;
#(
  parameter variant_t VARIANT = VAR_DIRECTION
) (
  input wire logic      clk,
  input wire logic      rst_n,
  input wire fetch_br_t fetch,
  input wire logic      loop_exit,
  input wire logic      order_hazard,
  input wire predict_t  pred,
  input wire logic      order_flush
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire st  = VARIANT != VAR_NO_STATIC;
  wire dir = VARIANT == VAR_DIRECTION;
  wire bwd = fetch.valid && fetch.kind == BR_COND && fetch.target <= fetch.pc;
  wire fwd = fetch.valid && fetch.kind == BR_COND && fetch.target > fetch.pc;
  sequence s_spin; fetch.valid && fetch.kind == BR_SPIN_HINT; endsequence
  sequence s_exit; loop_exit && order_hazard; endsequence
  property p_miss; fetch.valid && fetch.kind == BR_COND
    |=> pred.valid && (pred.from_history || pred.from_static == dir); endproperty
  property p_unc; st && fetch.valid && fetch.kind == BR_UNCOND
    |=> pred.from_history || pred.taken && pred.next_pc == $past(fetch.target); endproperty
  property p_ind; st && fetch.valid && fetch.kind inside {BR_INDIRECT, BR_IND_CALL}
    |=> pred.from_history || !pred.taken && pred.next_pc == $past(fetch.pc) + 32'h4; endproperty
  property p_back; dir && bwd |=> pred.from_history || pred.taken && pred.from_static; endproperty
  property p_fwd; dir && fwd
    |=> pred.from_history || !pred.taken && pred.next_pc == $past(fetch.pc) + 32'h4; endproperty
  property p_ns; !st && fetch.valid |=> !pred.from_static; endproperty
  property p_nop; s_spin |=> !pred.taken && pred.next_pc == $past(fetch.pc) + 32'h4; endproperty
  property p_guard; s_spin ##1 s_exit |=> !order_flush; endproperty
  property p_flush; order_flush |-> $past(loop_exit && order_hazard); endproperty
  a_miss: assert property (p_miss) else $error("miss source wrong");
  a_unc: assert property (p_unc) else $error("uncond not taken");
  a_ind: assert property (p_ind) else $error("indirect taken");
  a_back: assert property (p_back) else $error("backward not taken");
  a_fwd: assert property (p_fwd) else $error("forward taken");
  a_ns: assert property (p_ns) else $error("static used");
  a_nop: assert property (p_nop) else $error("hint redirected");
  a_guard: assert property (p_guard) else $error("flush in guard");
  a_flush: assert property (p_flush) else $error("flush without exit");
endmodule // sbp_asserts
bind static_branch_predictor sbp_asserts #(.VARIANT(VARIANT)) chk (.clk(clk), .rst_n(rst_n),
  .fetch(fetch), .loop_exit(loop_exit), .order_hazard(order_hazard), .pred(pred),
  .order_flush(order_flush));

// file: sim/fetch_model.sv
`timescale 1ns/100ps
module fetch_model
  import bp_pkg::*;
(
  input  wire fetch_br_t fetch,
  output logic           dyn_taken
);
  // Hash of pc; idle cycles give inverted pc bit 2, unused as fetch is not valid
  assign dyn_taken = fetch.valid ? ^fetch.pc[6:2] : ~fetch.pc[2];
endmodule // fetch_model

// file: sim/tb.sv
`timescale 1ns/100ps
module tb;
  import bp_pkg::*;
  logic      clk, rst_n, resolve_cond, loop_exit, order_hazard, dyn_taken;
  fetch_br_t fetch;
  resolve_t  resolve;
  predict_t  pr [3];
  logic      fl [3];
  int        miscompares, tests_run;
  fetch_model fm (.fetch(fetch), .dyn_taken(dyn_taken));
  for (genvar i = 0; i < 3; i++) begin : g
    static_branch_predictor #(.VARIANT(variant_t'(i))) dut (.clk(clk), .rst_n(rst_n),
      .fetch(fetch), .dyn_taken(dyn_taken), .resolve(resolve), .resolve_cond(resolve_cond),
      .loop_exit(loop_exit), .order_hazard(order_hazard), .pred(pr[i]), .order_flush(fl[i]));
  end
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] s, e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [32:0] exp_pred(int v, br_kind_t k, logic [31:0] p, t);
    logic tk;
    tk = k == BR_UNCOND || k == BR_COND && (v == 0 ? t <= p : ^p[6:2]);
    if (v == 2 && k inside {BR_UNCOND, BR_COND, BR_INDIRECT, BR_IND_CALL})
      tk = ^p[6:2];
    return {tk, tk ? t : p + 32'h4};
  endfunction
  function automatic logic exp_static(int v, br_kind_t k, logic h);
    if (h || v == 2)
      return 1'b0;
    return k inside {BR_UNCOND, BR_INDIRECT, BR_IND_CALL} || (k == BR_COND && v == 0);
  endfunction
  // h[0]: hit expected; h[1]: counter pushed below the taken threshold
  task automatic go(br_kind_t k, logic [31:0] p, t, logic [1:0] h);
    logic [32:0] ex;
    logic        es;
    fetch <= '{1'b1, k, p, t};
    resolve.valid <= 1'b0;
    @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      ex = h[1] ? {1'b0, p + 32'h4} : {1'b1, t};
      if (!h[0])
        ex = exp_pred(i, k, p, t);
      es = exp_static(i, k, h[0]);
      chk(33'(pr[i].from_history), 33'(h[0]));
      chk({31'h0, pr[i].valid, pr[i].from_static}, {32'h1, es});
      chk({pr[i].taken, pr[i].next_pc}, ex);
    end
  endtask
  // Valid is left up so back-to-back updates never rewrite it in one step
  task automatic res(logic [31:0] p, t, logic tk);
    fetch.valid <= 1'b0;
    resolve <= '{1'b1, p, t, tk};
    @(negedge clk);
  endtask
  task automatic pulse(logic e);
    fetch.valid <= 1'b0;
    resolve.valid <= 1'b0;
    loop_exit <= 1'b1;
    order_hazard <= 1'b1;
    @(negedge clk);
    loop_exit <= 1'b0;
    order_hazard <= 1'b0;
    for (int i = 0; i < 3; i++)
      chk(33'(fl[i]), 33'(e));
  endtask
  initial begin
    void'($urandom(32'h4cf9c625));
    {rst_n, resolve_cond, loop_exit, order_hazard} = 4'h4;
    rst_n = 0;
    fetch = '0;
    resolve = '0;
    miscompares = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    go(BR_COND, 32'h100, 32'h100, 2'h0);
    go(BR_COND, 32'h100, 32'h104, 2'h0);
    go(BR_COND, 32'hFFFF_FFFC, 32'h0, 2'h0);
    repeat (60) go(br_kind_t'($urandom_range(5)), $urandom & 32'hFFFF_FFFC, $urandom, 2'h0);
    res(32'h200, 32'h240, 1'b0);
    go(BR_COND, 32'h200, 32'h240, 2'h0);
    res(32'h200, 32'h240, 1'b1);
    go(BR_COND, 32'h200, 32'h240, 2'h1);
    res(32'h200, 32'h240, 1'b0);
    go(BR_COND, 32'h200, 32'h240, 2'h3);
    // Non-conditional update saturates the counter, so a not-taken resolve keeps it taken
    resolve_cond <= 1'b0;
    res(32'h400, 32'h480, 1'b1);
    res(32'h400, 32'h480, 1'b0);
    go(BR_UNCOND, 32'h400, 32'h480, 2'h1);
    go(BR_SPIN_HINT, 32'h300, 32'h0, 2'h0);
    pulse(1'b0);
    repeat (2) @(negedge clk);
    pulse(1'b0);
    @(negedge clk);
    pulse(1'b1);
    // Mid-run reset must empty the history: the entry at 0x400 now misses
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    go(BR_UNCOND, 32'h400, 32'h480, 2'h0);
    final_report;
  end
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    final_report;
  end
endmodule // tb
